// [hw/scan_pkg.sv]
// Shared constants and types for the host-mapped scan engines
package scan_pkg;

    // ------------------------------------------------------------
    // Host address decode
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int A_WIN_BIT = 12;
    localparam int A_ENG_BIT = 11;
    localparam int A_LEN_HI = 10;
    localparam int A_LEN_LO = 6;
    localparam int A_OP_HI = 5;
    localparam int A_OP_LO = 4;
    localparam int A_TRL_BIT = 3;
    localparam int A_HDR_BIT = 2;
    localparam int ONESHOT_ENG_RST_BIT = 2;
    localparam int NUM_ENG = 2;

    // ------------------------------------------------------------
    // Operation codes and state-walk patterns (TMS, first bit in LSB)
    // ------------------------------------------------------------
    localparam logic [1:0] OP_DR = 2'h1;
    localparam logic [1:0] OP_IR = 2'h2;
    localparam logic [1:0] OP_RST = 2'h3;
    localparam logic [7:0] PAT_HDR_DR = 8'h01;
    localparam logic [7:0] PAT_HDR_IR = 8'h03;
    localparam logic [7:0] PAT_TRL = 8'h01;
    localparam logic [7:0] PAT_RST = 8'h1F;
    localparam logic [5:0] CNT_HDR_DR = 6'h03;
    localparam logic [5:0] CNT_HDR_IR = 6'h04;
    localparam logic [5:0] CNT_TRL = 6'h02;
    localparam logic [5:0] CNT_RST = 6'h06;
    localparam logic [5:0] FULL_WORD = 6'h20;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TCK_HALF_NS = 100;
    localparam int TCK_HALF_CYC_I = (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TCK_HALF_CYC = 4'(TCK_HALF_CYC_I);
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [5:0] len;
        logic [1:0] op;
        logic trl;
        logic hdr;
        logic [31:0] data;
    } scan_cmd_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scan_pins_t;

endpackage : scan_pkg

// [hw/scan_engine.sv]
// One scan engine: TCK generation, header, shift and trailer sequencing
`timescale 1ns/100ps
module scan_engine
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic eng_rst,
    input wire logic start,
    input scan_pkg::scan_cmd_t cmd,
    input wire logic tdo_s,
    output scan_pkg::scan_pins_t pins_q,
    output logic busy_q,
    output logic [31:0] cap_q
);
    import scan_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_HDR, S_SHIFT, S_TRL, S_RST} eng_state_t;

    eng_state_t state_q;
    scan_cmd_t cmd_q;
    logic [3:0] div_q;
    logic [5:0] cnt_q;
    logic [7:0] pat_q;
    logic [31:0] dat_q;
    logic clr;
    logic edge_t;
    logic rise;
    logic fall;

    assign clr = !rst_n || eng_rst;
    assign edge_t = (state_q != S_IDLE) && (div_q == TCK_HALF_CYC - 4'h1);
    assign rise = edge_t && !pins_q.tck;
    assign fall = edge_t && pins_q.tck;

    // ------------------------------------------------------------
    // TCK divider: runs only while a sequence is active
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (clr || state_q == S_IDLE || edge_t)
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (clr)
            pins_q.tck <= 1'b0;
        else if (edge_t)
            pins_q.tck <= ~pins_q.tck;
    end

    // ------------------------------------------------------------
    // Sequencer: a slot is one TCK period; TMS/TDI change at its start
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (clr)
        begin
            state_q <= S_IDLE;
            cnt_q <= 6'h00;
            pat_q <= 8'h00;
            dat_q <= 32'h0000_0000;
            cmd_q <= '0;
            pins_q.tms <= 1'b0;
            pins_q.tdi <= 1'b0;
        end
        else if (state_q == S_IDLE)
        begin
            if (start && cmd.op != 2'h0)
            begin
                cmd_q <= cmd;
                dat_q <= cmd.data;
                pins_q.tdi <= 1'b0;
                if (cmd.op == OP_RST)
                begin
                    // Five TMS highs reach reset, one low parks in idle
                    state_q <= S_RST;
                    pat_q <= PAT_RST;
                    cnt_q <= CNT_RST;
                    pins_q.tms <= PAT_RST[0];
                end
                else if (cmd.hdr)
                begin
                    // Walk from idle into the selected shift state
                    state_q <= S_HDR;
                    pat_q <= (cmd.op == OP_IR) ? PAT_HDR_IR : PAT_HDR_DR;
                    cnt_q <= (cmd.op == OP_IR) ? CNT_HDR_IR : CNT_HDR_DR;
                    pins_q.tms <= 1'b1;
                end
                else
                begin
                    state_q <= S_SHIFT;
                    cnt_q <= cmd.len;
                    pins_q.tdi <= cmd.data[0];
                    pins_q.tms <= cmd.trl && (cmd.len == 6'h01);
                end
            end
        end
        else if (fall)
        begin
            cnt_q <= cnt_q - 6'h01;
            pat_q <= pat_q >> 1;
            unique case (state_q)
                S_HDR:
                begin
                    if (cnt_q == 6'h01)
                    begin
                        state_q <= S_SHIFT;
                        cnt_q <= cmd_q.len;
                        pins_q.tdi <= dat_q[0];
                        pins_q.tms <= cmd_q.trl && (cmd_q.len == 6'h01);
                    end
                    else
                        pins_q.tms <= pat_q[1];
                end
                S_SHIFT:
                begin
                    // Only the low len bits of the word ever reach TDI
                    dat_q <= dat_q >> 1;
                    pins_q.tdi <= dat_q[1];
                    pins_q.tms <= cmd_q.trl && (cnt_q == 6'h02);
                    if (cnt_q == 6'h01)
                    begin
                        pins_q.tdi <= 1'b0;
                        if (cmd_q.trl)
                        begin
                            // Last shift bit left via exit; update then idle
                            state_q <= S_TRL;
                            pat_q <= PAT_TRL;
                            cnt_q <= CNT_TRL;
                            pins_q.tms <= PAT_TRL[0];
                        end
                        else
                        begin
                            state_q <= S_IDLE;
                            pins_q.tms <= 1'b0;
                        end
                    end
                end
                S_TRL, S_RST:
                begin
                    if (cnt_q == 6'h01)
                    begin
                        state_q <= S_IDLE;
                        pins_q.tms <= 1'b0;
                    end
                    else
                        pins_q.tms <= pat_q[1];
                end
                S_IDLE:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Capture: TDO sampled on each rising TCK of the shift
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (clr)
            cap_q <= 32'h0000_0000;
        else if (state_q == S_SHIFT && rise)
            cap_q <= {tdo_s, cap_q[31:1]};
        else if (state_q == S_SHIFT && fall && cnt_q == 6'h01)
            // Right-align short shifts so bit 0 is the first bit out
            cap_q <= cap_q >> (FULL_WORD - cmd_q.len);
    end

    always_ff @(posedge clk_sys)
    begin
        if (clr)
            busy_q <= 1'b0;
        else
            busy_q <= (state_q != S_IDLE) || (start && cmd.op != 2'h0);
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (clr);

    logic [5:0] nbits_q;
    always_ff @(posedge clk_sys)
    begin
        if (clr || state_q != S_SHIFT)
            nbits_q <= 6'h00;
        else if (rise)
            nbits_q <= nbits_q + 6'h01;
    end

    a_shift_bit_count: assert property (
        (state_q == S_SHIFT && fall && cnt_q == 6'h01) |-> (nbits_q == cmd_q.len))
        else $error("shift length differs from programmed count");
    a_tdi_low_bits: assert property (
        (state_q == S_SHIFT && rise) |-> (pins_q.tdi == cmd_q.data[nbits_q[4:0]]))
        else $error("TDI bit not taken from the low data bits");
    a_reset_walk: assert property (
        (state_q == S_IDLE && start && cmd.op == OP_RST) |=> (state_q == S_RST && pins_q.tms))
        else $error("reset operation did not start a TMS-high walk");
    a_trailer_exit: assert property (
        (state_q == S_SHIFT && rise && cnt_q == 6'h01) |-> (pins_q.tms == cmd_q.trl))
        else $error("last shift bit TMS does not follow post_shift_exit_enable");
    a_header_ir_walk: assert property (
        (state_q == S_HDR && rise && cmd_q.op == OP_IR) |->
            (pins_q.tms == (cnt_q > 6'h02)))
        else $error("instruction header TMS pattern wrong");
    a_no_restart: assert property (
        (state_q != S_IDLE) |=> $stable(cmd_q))
        else $error("command taken while a sequence was running");
    c_dr_full: cover property (state_q == S_TRL && cmd_q.op == OP_DR && cmd_q.hdr);
    c_ir_shift: cover property (state_q == S_SHIFT && cmd_q.op == OP_IR && cmd_q.len == 6'h20);

endmodule : scan_engine

// [hw/host_scan_engine.sv]
// Host-mapped pair of scan engines with read-back of captured TDO data
`timescale 1ns/100ps

module host_scan_engine
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input scan_pkg::host_req_t req,
    input wire logic oneshot_wr,
    input wire logic [31:0] oneshot_data,
    input wire logic [scan_pkg::NUM_ENG-1:0] tdo,
    output scan_pkg::scan_pins_t [scan_pkg::NUM_ENG-1:0] pins_q,
    output logic [scan_pkg::NUM_ENG-1:0] busy_q,
    output logic [31:0] rdata_q,
    output logic rd_valid_q
);
    import scan_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic hit_engine(input logic [ADDR_W-1:0] a, input int e);
        return a[A_WIN_BIT] && (a[A_ENG_BIT] == e[0]);
    endfunction : hit_engine

    function automatic scan_cmd_t decode_cmd(input host_req_t r);
        scan_cmd_t c;
        c.len = {1'b0, r.addr[A_LEN_HI:A_LEN_LO]} + 6'h01;
        c.op = r.addr[A_OP_HI:A_OP_LO];
        c.trl = r.addr[A_TRL_BIT];
        c.hdr = r.addr[A_HDR_BIT];
        c.data = r.wdata;
        return c;
    endfunction : decode_cmd

    // ------------------------------------------------------------
    // One-shot engine reset
    // ------------------------------------------------------------
    logic eng_rst_q;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            eng_rst_q <= 1'b0;
        else
            eng_rst_q <= oneshot_wr && oneshot_data[ONESHOT_ENG_RST_BIT];
    end

    // ------------------------------------------------------------
    // Engines
    // ------------------------------------------------------------
    scan_cmd_t cmd;
    logic [31:0] cap [NUM_ENG];
    logic [NUM_ENG-1:0] start;

    assign cmd = decode_cmd(req);

    genvar g;
    generate
        for (g = 0; g < NUM_ENG; g++)
        begin : g_eng
            logic tdo_m_q;
            logic tdo_s_q;

            // TDO arrives from the target's domain; only the second flop is read
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    tdo_m_q <= 1'b0;
                    tdo_s_q <= 1'b0;
                end
                else
                begin
                    tdo_m_q <= tdo[g];
                    tdo_s_q <= tdo_m_q;
                end
            end

            // Writes to a running engine are dropped, not queued
            assign start[g] = req.wr && hit_engine(req.addr, g) && !busy_q[g];

            scan_engine u_eng
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .eng_rst(eng_rst_q),
                .start(start[g]),
                .cmd(cmd),
                .tdo_s(tdo_s_q),
                .pins_q(pins_q[g]),
                .busy_q(busy_q[g]),
                .cap_q(cap[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read-back: whole word, engine picked by bit 11 alone
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdata_q <= RDATA_RST;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= req.rd && req.addr[A_WIN_BIT];
            if (req.rd && req.addr[A_WIN_BIT])
                rdata_q <= cap[req.addr[A_ENG_BIT]];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req.rd && req.addr[A_WIN_BIT]) |=>
            (rd_valid_q && rdata_q == $past(cap[req.addr[A_ENG_BIT]])))
        else $error("read did not return the captured word");
    a_read_low_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req.rd && req.addr[A_WIN_BIT] && !req.addr[A_ENG_BIT]) |=> (rdata_q == $past(cap[0])))
        else $error("read of engine 0 depended on low address bits");
    a_window_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req.wr && !req.addr[A_WIN_BIT] && busy_q == '0) |=> (busy_q == '0))
        else $error("engine started outside the scan window");
    a_engine_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req.wr && req.addr[A_WIN_BIT] && req.addr[A_ENG_BIT] && busy_q == '0) |=> !busy_q[0])
        else $error("engine 1 write started engine 0");
    a_oneshot_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (oneshot_wr && oneshot_data[ONESHOT_ENG_RST_BIT]) |=> ##1 (busy_q == '0 && !pins_q[0].tck))
        else $error("one-shot reset did not idle the engines");
    a_read_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(req.rd && req.addr[A_WIN_BIT]) |=> !rd_valid_q)
        else $error("read outside the scan window answered");
    a_read_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(req.rd && req.addr[A_WIN_BIT]) |=> $stable(rdata_q))
        else $error("read data changed without a window read");
    a_noop_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req.wr && req.addr[A_OP_HI:A_OP_LO] == 2'h0 && busy_q == '0) |=> (busy_q == '0))
        else $error("write with no operation code started an engine");
    c_eng_reset_busy: cover property (@(posedge clk_sys) disable iff (!rst_n)
        eng_rst_q && busy_q[0]);

    // ------------------------------------------------------------
    // Per-engine pin checks
    // ------------------------------------------------------------
    generate
        for (g = 0; g < NUM_ENG; g++)
        begin : g_chk
            logic tck_prev_q;
            logic [3:0] tck_high_q;

            // Times the high phase; an engine reset may cut it short
            always_ff @(posedge clk_sys)
            begin
                tck_prev_q <= pins_q[g].tck;
                if (!rst_n || eng_rst_q || !pins_q[g].tck)
                    tck_high_q <= 4'h0;
                else
                    tck_high_q <= tck_high_q + 4'h1;
            end

            a_tck_high_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
                (tck_prev_q && !pins_q[g].tck && !$past(eng_rst_q)) |->
                    (tck_high_q == TCK_HALF_CYC))
                else $error("TCK high phase has the wrong length");
            a_idle_parked: assert property (@(posedge clk_sys) disable iff (!rst_n)
                !busy_q[g] |-> (pins_q[g] == '0))
                else $error("scan pins not parked while engine idle");
            a_start_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
                (start[g] && cmd.op != 2'h0 && !eng_rst_q) |=> busy_q[g])
                else $error("accepted write did not make the engine busy");
            a_pins_at_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
                ($changed(pins_q[g].tms) || $changed(pins_q[g].tdi)) |-> !pins_q[g].tck)
                else $error("TMS or TDI changed while TCK was high");
        end
    endgenerate
    c_read_back: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rd_valid_q && rdata_q != 32'h0000_0000);
    c_reset_op: cover property (@(posedge clk_sys) disable iff (!rst_n)
        start[1] && cmd.op == OP_RST);

endmodule : host_scan_engine

// [dv/scan_target_model.sv]
// Behavioural scan-chain target: test state machine with data and instruction registers
`timescale 1ns/100ps
module scan_target_model
#(
    parameter logic [31:0] DR_CAPTURE = 32'hC3A5_5A3C,
    parameter logic [31:0] IR_CAPTURE = 32'h9E1D_27B4
)
(
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic [3:0] state_q,
    output logic [31:0] dr_q,
    output logic [31:0] ir_q
);
    // ------------------------------------------------------------
    // State walk, 0 reset, 1 idle, 4 data shift, B instruction shift
    // ------------------------------------------------------------
    function automatic logic [3:0] next_state(input logic [3:0] s, input logic m);
        case (s)
            4'h0: next_state = m ? 4'h0 : 4'h1;
            4'h1: next_state = m ? 4'h2 : 4'h1;
            4'h2: next_state = m ? 4'h9 : 4'h3;
            4'h3: next_state = m ? 4'h5 : 4'h4;
            4'h4: next_state = m ? 4'h5 : 4'h4;
            4'h5: next_state = m ? 4'h8 : 4'h6;
            4'h6: next_state = m ? 4'h7 : 4'h6;
            4'h7: next_state = m ? 4'h8 : 4'h4;
            4'h9: next_state = m ? 4'h0 : 4'hA;
            4'hA: next_state = m ? 4'hC : 4'hB;
            4'hB: next_state = m ? 4'hC : 4'hB;
            4'hC: next_state = m ? 4'hF : 4'hD;
            4'hD: next_state = m ? 4'hE : 4'hD;
            4'hE: next_state = m ? 4'hF : 4'hB;
            default: next_state = m ? 4'h2 : 4'h1;
        endcase
    endfunction : next_state

    // Powers up in reset (state 0): the engine must walk the target to idle itself
    initial
    begin
        state_q = 4'h0;
        dr_q = 32'h0000_0000;
        ir_q = 32'h0000_0000;
        tdo = 1'b0;
    end

    always @(posedge tck)
    begin
        if (state_q == 4'h3) dr_q <= DR_CAPTURE;
        if (state_q == 4'hA) ir_q <= IR_CAPTURE;
        if (state_q == 4'h4) dr_q <= {tdi, dr_q[31:1]};
        if (state_q == 4'hB) ir_q <= {tdi, ir_q[31:1]};
        state_q <= next_state(state_q, tms);
    end

    // Outside a shift the line is not driven; toggling keeps stale data from matching
    always @(negedge tck)
    begin
        if (state_q == 4'h4) tdo <= dr_q[0];
        else if (state_q == 4'hB) tdo <= ir_q[0];
        else tdo <= ~tdo;
    end
endmodule : scan_target_model

// [dv/host_scan_engine_tb.sv]
// Self-checking bench for the host-mapped scan engine pair
`timescale 1ns/100ps
module host_scan_engine_tb;
    import scan_pkg::*;

    // ------------------------------------------------------------
    // Wiring
    // ------------------------------------------------------------
    localparam logic [31:0] DR_CAP = 32'hC3A5_5A3C;
    localparam logic [31:0] IR_CAP = 32'h9E1D_27B4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    host_req_t req = '0;
    logic oneshot_wr = 1'b0;
    logic [31:0] oneshot_data = 32'h0000_0000;
    logic [NUM_ENG-1:0] tdo;
    scan_pins_t [NUM_ENG-1:0] pins_q;
    logic [NUM_ENG-1:0] busy_q;
    logic [31:0] rdata_q;
    logic rd_valid_q;
    logic [3:0] tap_st [NUM_ENG];
    logic [31:0] tap_dr [NUM_ENG];
    logic [31:0] tap_ir [NUM_ENG];
    int num_errors = 0;
    int checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    host_scan_engine uut
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .req(req),
        .oneshot_wr(oneshot_wr),
        .oneshot_data(oneshot_data),
        .tdo(tdo),
        .pins_q(pins_q),
        .busy_q(busy_q),
        .rdata_q(rdata_q),
        .rd_valid_q(rd_valid_q)
    );

    for (genvar e = 0; e < NUM_ENG; e++)
    begin : g_tgt
        scan_target_model #(.DR_CAPTURE(DR_CAP), .IR_CAPTURE(IR_CAP)) tgt
        (
            .tck(pins_q[e].tck),
            .tms(pins_q[e].tms),
            .tdi(pins_q[e].tdi),
            .tdo(tdo[e]),
            .state_q(tap_st[e]),
            .dr_q(tap_dr[e]),
            .ir_q(tap_ir[e])
        );
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic print_verdict();
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic wait_idle(input logic eng);
        int n;
        n = 0;
        while (busy_q[eng] !== 1'b0 && n < 1000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 1000)
        begin
            num_errors++;
            print_verdict();
        end
    endtask : wait_idle

    // Issues one write and checks that the engine took it or refused it
    task automatic host_wr(input logic win, input logic eng, input logic [5:0] len,
        input logic [1:0] op, input logic trl, input logic hdr, input logic [31:0] data,
        input logic taken);
        @(negedge clk_sys);
        req.wr = 1'b1;
        req.addr = {win, eng, 5'(len - 6'h01), op, trl, hdr, 2'b00};
        req.wdata = data;
        @(negedge clk_sys);
        req.wr = 1'b0;
        @(negedge clk_sys);
        check_val("busy after write", {31'h0, taken}, {31'h0, busy_q[eng]});
    endtask : host_wr

    task automatic host_rd(input logic win, input logic eng, input logic [10:0] low,
        input logic vld, input logic [31:0] exp, input logic [31:0] mask);
        @(negedge clk_sys);
        req.rd = 1'b1;
        req.addr = {win, eng, low};
        @(negedge clk_sys);
        req.rd = 1'b0;
        check_val("read valid", {31'h0, vld}, {31'h0, rd_valid_q});
        if (vld) check_val("read data", exp & mask, rdata_q & mask);
    endtask : host_rd

    task automatic oneshot(input logic [31:0] data);
        @(negedge clk_sys);
        oneshot_wr = 1'b1;
        oneshot_data = data;
        @(negedge clk_sys);
        oneshot_wr = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : oneshot

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_tap_reset();
        for (int e = 0; e < NUM_ENG; e++)
        begin
            host_wr(1'b1, 1'(e), 6'h01, OP_RST, 1'b0, 1'b0, 32'h0, 1'b1);
            wait_idle(1'(e));
            check_val("target idle", 32'h1, 32'(tap_st[e]));
            check_val("tck idle", 32'h0, 32'(pins_q[e].tck));
        end
    endtask : sc_tap_reset

    // Split data shift: header only, then trailer only, upper word bits set
    task automatic sc_dr_split();
        host_wr(1'b1, 1'b0, 6'h08, OP_DR, 1'b0, 1'b1, 32'hFFFF_FFA5, 1'b1);
        wait_idle(1'b0);
        check_val("in data shift", 32'h4, 32'(tap_st[0]));
        host_rd(1'b1, 1'b0, 11'h000, 1'b1, DR_CAP, 32'hFF);
        host_wr(1'b1, 1'b0, 6'h08, OP_DR, 1'b1, 1'b0, 32'h1234_565A, 1'b1);
        wait_idle(1'b0);
        check_val("back to idle", 32'h1, 32'(tap_st[0]));
        check_val("data shifted", {16'h5AA5, DR_CAP[31:16]}, tap_dr[0]);
        host_rd(1'b1, 1'b0, 11'h7FC, 1'b1, {24'h0, DR_CAP[15:8]}, 32'hFF);
    endtask : sc_dr_split

    // Full-width instruction shift and a one-bit data shift on the second engine
    task automatic sc_eng1();
        host_wr(1'b1, 1'b1, 6'h20, OP_IR, 1'b1, 1'b1, 32'h8421_F00D, 1'b1);
        host_wr(1'b1, 1'b1, 6'h01, OP_RST, 1'b0, 1'b0, 32'h0, 1'b1);
        wait_idle(1'b1);
        check_val("instr shifted", 32'h8421_F00D, tap_ir[1]);
        check_val("idle after instr", 32'h1, 32'(tap_st[1]));
        host_rd(1'b1, 1'b1, 11'h3C0, 1'b1, IR_CAP, 32'hFFFF_FFFF);
        check_val("other engine untouched", 32'h0, tap_ir[0]);
        host_wr(1'b1, 1'b1, 6'h01, OP_DR, 1'b1, 1'b1, 32'hFFFF_FFFF, 1'b1);
        wait_idle(1'b1);
        check_val("one bit shifted", {1'b1, DR_CAP[31:1]}, tap_dr[1]);
        host_rd(1'b1, 1'b1, 11'h000, 1'b1, DR_CAP, 32'h1);
    endtask : sc_eng1

    task automatic sc_refused();
        host_wr(1'b0, 1'b0, 6'h08, OP_DR, 1'b1, 1'b1, 32'h0F0F_0F0F, 1'b0);
        host_wr(1'b1, 1'b0, 6'h08, 2'b00, 1'b1, 1'b1, 32'h0F0F_0F0F, 1'b0);
        host_rd(1'b0, 1'b1, 11'h000, 1'b0, 32'h0, 32'h0);
    endtask : sc_refused

    // Engine reset in mid-shift; a one-shot word without bit 2 must not stop it
    task automatic sc_oneshot();
        host_wr(1'b1, 1'b0, 6'h20, OP_DR, 1'b1, 1'b1, 32'h55AA_33CC, 1'b1);
        repeat (40) @(negedge clk_sys);
        oneshot(32'hFFFF_FFFB);
        check_val("busy kept", 32'h1, 32'(busy_q[0]));
        oneshot(32'h0000_0004);
        check_val("busy cleared", 32'h0, 32'(busy_q));
        check_val("pins cleared", 32'h0, 32'(pins_q));
        host_rd(1'b1, 1'b0, 11'h000, 1'b1, RDATA_RST, 32'hFFFF_FFFF);
        sc_tap_reset();
    endtask : sc_oneshot

    initial
    begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        host_rd(1'b1, 1'b0, 11'h000, 1'b1, RDATA_RST, 32'hFFFF_FFFF);
        sc_tap_reset();
        sc_dr_split();
        sc_eng1();
        sc_refused();
        sc_oneshot();
        print_verdict();
    end
endmodule : host_scan_engine_tb
